// [pmcr_consts.svh]
// constants of the phy management control register block
// assumes inclusion by bare name from every file that needs them
`ifndef PMCR_CONSTS_SVH
`define PMCR_CONSTS_SVH

`define PMCR_ADDR_W          5
`define PMCR_DATA_W          16
`define PMCR_CTRL_OFFSET     5'h00
`define PMCR_CTRL_RESET      16'h3000
`define PMCR_BIT_RESET       15
`define PMCR_BIT_LOOPBACK    14
`define PMCR_BIT_SPEED       13
`define PMCR_BIT_AN_EN       12
`define PMCR_BIT_PWR_DOWN    11
`define PMCR_BIT_AN_RESTART  9
`define PMCR_BIT_DUPLEX      8
`define PMCR_BIT_COLL_TEST   7
`define PMCR_WRITE_MASK      16'h7b80
`define PMCR_CLK_MHZ         25
`define PMCR_DEAD_NS         560
`define PMCR_DEAD_CYCLES     ((`PMCR_DEAD_NS * `PMCR_CLK_MHZ) / 1000)
`define PMCR_SOFT_RST_CYCLES 16

`endif

// [pmcr_lpbk.sv]
// receive path select: line or looped-back transmit nibbles, plus collision
// assumes all inputs synchronous to clk_sys_i
`timescale 1ns/100ps
`include "pmcr_consts.svh"

module pmcr_lpbk (
    input  wire logic                  clk_sys_i,
    input  wire logic                  reset_n_i,
    input  wire logic                  lpbk_i,
    input  wire logic                  coll_test_i,
    input  wire logic                  power_down_i,
    input  wire logic                  tx_en_i,
    input  wire logic [3:0]            txd_i,
    input  wire pmcr_pkg::pmcr_nibble_t line_rx_i,
    input  wire logic                  line_col_i,
    output pmcr_pkg::pmcr_nibble_t     rx_o,
    output logic                       col_o,
    output logic                       dead_o
);

    localparam logic [4:0] DEAD_LOAD = 5'(`PMCR_DEAD_CYCLES);

    pmcr_pkg::pmcr_nibble_t rx_r;
    pmcr_pkg::pmcr_nibble_t rx_nxt;
    logic                   col_r;
    logic                   col_nxt;
    logic                   lpbk_d_r;
    logic [4:0]             dead_r;
    logic [4:0]             dead_nxt;
    logic                   dead_flag_r;
    logic                   dead_flag_nxt;

    always_comb begin
        dead_nxt = dead_r;
        if (lpbk_i && !lpbk_d_r) begin
            dead_nxt = DEAD_LOAD;
        end else if (dead_r != 5'h00) begin
            dead_nxt = dead_r - 5'h01;
        end
        // flag kept in its own flop so the top output is registered
        dead_flag_nxt = (dead_nxt != 5'h00);
        rx_nxt = '0;
        if (power_down_i) begin
            rx_nxt = '0;
        end else if (lpbk_i) begin
            // line input is ignored entirely while looped
            rx_nxt.dv = tx_en_i && (dead_nxt == 5'h00);
            rx_nxt.d  = txd_i;
        end else begin
            rx_nxt = line_rx_i;
        end
        col_nxt = (coll_test_i && tx_en_i) || (!lpbk_i && !power_down_i && line_col_i);
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            rx_r     <= '0;
            col_r    <= 1'b0;
            lpbk_d_r <= 1'b0;
            dead_r   <= 5'h00;
            dead_flag_r <= 1'b0;
        end else begin
            rx_r     <= rx_nxt;
            col_r    <= col_nxt;
            lpbk_d_r <= lpbk_i;
            dead_r   <= dead_nxt;
            dead_flag_r <= dead_flag_nxt;
        end
    end

    assign rx_o   = rx_r;
    assign col_o  = col_r;
    assign dead_o = dead_flag_r;

endmodule

// [pmcr_mac_model.sv]
// controller side of the management port: one transfer per task call
// assumes calls start 1 ns after a rising edge of clk_i
`timescale 1ns/100ps

module pmcr_mac_model (
    input  wire logic        clk_i,
    input  wire logic        ack_i,
    input  wire logic [15:0] rdata_i,
    output logic             req_o,
    output logic             wr_o,
    output logic [4:0]       addr_o,
    output logic [15:0]      wdata_o
);
initial begin
    req_o = 1'b0;
    wr_o = 1'b0;
    addr_o = 5'h00;
    wdata_o = 16'h0000;
end

// strobe lasts one cycle; the answer is taken in the cycle after it
task automatic xfer(input logic w, input logic [4:0] a, input logic [15:0] d,
                    output logic ack, output logic [15:0] q);
    req_o = 1'b1;
    wr_o = w;
    addr_o = a;
    wdata_o = d;
    @(posedge clk_i);
    #1;
    req_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
    ack = ack_i;
    q = rdata_i;
    @(posedge clk_i);
    #1;
endtask
endmodule

// [pmcr_monitor.sv]
// concurrent checks on the phy control register top-level ports
// assumes a bind onto pmcr_top, one clock, synchronous active-low reset
`timescale 1ns/100ps
`include "pmcr_consts.svh"

module pmcr_monitor #(
    parameter int SOFT_RST_CYCLES = `PMCR_SOFT_RST_CYCLES
) (
    input wire logic                   clk_sys_i,
    input wire logic                   reset_n_i,
    input wire logic                   mgmt_req_i,
    input wire logic                   mgmt_wr_i,
    input wire logic [`PMCR_ADDR_W-1:0] mgmt_addr_i,
    input wire logic [`PMCR_DATA_W-1:0] mgmt_wdata_i,
    input wire logic                   mgmt_ack_o,
    input wire logic [`PMCR_DATA_W-1:0] mgmt_rdata_o,
    input wire logic                   mgmt_busy_o,
    input wire logic                   cfg_lpbk_valid_i,
    input wire logic                   cfg_lpbk_i,
    input wire logic                   cap_full_i,
    input wire logic                   cap_half_i,
    input wire logic                   tx_en_i,
    input wire logic [3:0]             txd_i,
    input wire logic                   rx_dv_o,
    input wire logic [3:0]             rxd_o,
    input wire logic                   rx_dead_o,
    input wire logic                   loopback_o,
    input wire logic                   full_duplex_o,
    input wire logic                   an_enable_o,
    input wire logic                   an_restart_o,
    input wire logic                   power_down_o
);
default clocking cb @(posedge clk_sys_i); endclocking
default disable iff (!reset_n_i);

////////////////////////////////////////////////////////////////////////////////
// run lengths of dead time and busy, so their exact spans can be judged
logic [7:0] dead_r, dead_nxt, busy_r, busy_nxt;
logic       ctl_wr;
assign ctl_wr = mgmt_req_i && mgmt_wr_i && !mgmt_busy_o && mgmt_addr_i == `PMCR_CTRL_OFFSET;
always_comb begin
    dead_nxt = rx_dead_o ? dead_r + 8'h01 : 8'h00;
    busy_nxt = mgmt_busy_o ? busy_r + 8'h01 : 8'h00;
end
always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
        dead_r <= 8'h00;
        busy_r <= 8'h00;
    end else begin
        dead_r <= dead_nxt;
        busy_r <= busy_nxt;
    end
end

////////////////////////////////////////////////////////////////////////////////
ack_answer_a: assert property (mgmt_req_i && !(mgmt_wr_i && mgmt_busy_o) |=> mgmt_ack_o)
    else $error("request taken without answer");
refused_write_a: assert property (mgmt_req_i && mgmt_wr_i && mgmt_busy_o |=> !mgmt_ack_o)
    else $error("write answered during soft reset");
unmapped_zero_a: assert property (mgmt_req_i && !mgmt_wr_i && mgmt_addr_i != 5'h00 |=> mgmt_rdata_o == 16'h0000)
    else $error("unmapped read not zero");
soft_reset_a: assert property (ctl_wr && mgmt_wdata_i[15] |=> mgmt_busy_o ##1 an_enable_o && !power_down_o)
    else $error("soft reset did not restore defaults");
busy_len_a: assert property ($fell(mgmt_busy_o) |-> busy_r == SOFT_RST_CYCLES)
    else $error("soft reset length wrong");
restart_pulse_a: assert property (ctl_wr && mgmt_wdata_i[9] && !mgmt_wdata_i[15] |=> an_restart_o ##1 !an_restart_o)
    else $error("restart not a single pulse");
dead_len_a: assert property ($fell(rx_dead_o) |-> dead_r == `PMCR_DEAD_CYCLES)
    else $error("dead time length wrong");
loop_data_a: assert property (loopback_o && $past(loopback_o) && !rx_dead_o && !$past(rx_dead_o)
    && !power_down_o && !$past(power_down_o) |-> rxd_o == $past(txd_i) && rx_dv_o == $past(tx_en_i))
    else $error("looped nibble mismatch");
cfg_wins_a: assert property ((cfg_lpbk_valid_i && !cfg_lpbk_i) [*3] |-> !loopback_o)
    else $error("configured loopback not obeyed");
single_duplex_a: assert property ((cap_half_i && !cap_full_i) [*3] |-> !full_duplex_o || loopback_o)
    else $error("duplex not pinned to half");
cfg_forces_on_a: assert property ((cfg_lpbk_valid_i && cfg_lpbk_i) [*3] |-> loopback_o)
    else $error("configured loopback not entered");
endmodule

bind pmcr_top pmcr_monitor #(.SOFT_RST_CYCLES(SOFT_RST_CYCLES)) i_pmcr_monitor (.clk_sys_i, .reset_n_i,
    .mgmt_req_i, .mgmt_wr_i, .mgmt_addr_i, .mgmt_wdata_i, .mgmt_ack_o, .mgmt_rdata_o, .mgmt_busy_o,
    .cfg_lpbk_valid_i, .cfg_lpbk_i, .cap_full_i, .cap_half_i, .tx_en_i, .txd_i, .rx_dv_o, .rxd_o,
    .rx_dead_o, .loopback_o, .full_duplex_o, .an_enable_o, .an_restart_o, .power_down_o);

// [pmcr_pkg.sv]
// types of the phy management control register block
// assumes pmcr_consts.svh for widths
`include "pmcr_consts.svh"

package pmcr_pkg;

    typedef struct packed {
        logic       soft_reset;
        logic       loopback;
        logic       speed100;
        logic       an_enable;
        logic       power_down;
        logic       rsvd10;
        logic       an_restart;
        logic       full_duplex;
        logic       coll_test;
        logic [6:0] rsvd6_0;
    } pmcr_ctrl_t;

    typedef struct packed {
        logic       dv;
        logic [3:0] d;
    } pmcr_nibble_t;

endpackage

// [pmcr_rst_seq.sv]
// soft reset sequencer: holds busy for a fixed number of cycles
// assumes start_i is a one-cycle pulse in the system clock domain
`timescale 1ns/100ps
`include "pmcr_consts.svh"

module pmcr_rst_seq #(
    parameter int RST_CYCLES = `PMCR_SOFT_RST_CYCLES
) (
    input  wire logic clk_sys_i,
    input  wire logic reset_n_i,
    input  wire logic start_i,
    output logic      busy_o
);

    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic        busy_r;
    logic        busy_nxt;

    always_comb begin
        cnt_nxt  = cnt_r;
        busy_nxt = busy_r;
        if (start_i) begin
            busy_nxt = 1'b1;
            cnt_nxt  = 16'(RST_CYCLES - 1);
        end else if (busy_r) begin
            if (cnt_r == 16'h0000) begin
                busy_nxt = 1'b0;
            end else begin
                cnt_nxt = cnt_r - 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            cnt_r  <= 16'h0000;
            busy_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            busy_r <= busy_nxt;
        end
    end

    assign busy_o = busy_r;

endmodule

// [pmcr_top.sv]
// phy basic control register with its management port and effects
// assumes a single management master synchronous to clk_sys_i
//
// Notes on behaviour
// - register sits behind the management port inside control/status space
// - writing one to bit 15 restores defaults, then the bit self-clears
// - during soft reset bit 15 reads one; writes are refused
// - bit 14 loops transmit nibbles into the receive path
// - while looped, line receive activity is cut off
// - entering loopback gives up to 560 ns of invalid receive data
// - device loopback configuration overrides the register loopback bit
// - with negotiation off, bit 13 forces 100 or 10 Mbps
// - bit 12 enables negotiation; forced speed and duplex then ignored
// - bit 11 puts the phy in low power
// - writing one to bit 9 restarts negotiation, bit self-clears
// - with negotiation off, bit 8 forces full or half duplex
// - single supported duplex mode pins the duplex bit to it
// - in loopback, behaviour ignores the duplex bit
// - bit 7 forces collision whenever transmit enable is high
`timescale 1ns/100ps
`include "pmcr_consts.svh"

module pmcr_top #(
    parameter int SOFT_RST_CYCLES = `PMCR_SOFT_RST_CYCLES
) (
    input  wire logic                     clk_sys_i,
    input  wire logic                     reset_n_i,
    input  wire logic                     mgmt_req_i,
    input  wire logic                     mgmt_wr_i,
    input  wire logic [`PMCR_ADDR_W-1:0]  mgmt_addr_i,
    input  wire logic [`PMCR_DATA_W-1:0]  mgmt_wdata_i,
    output logic                          mgmt_ack_o,
    output logic [`PMCR_DATA_W-1:0]       mgmt_rdata_o,
    output logic                          mgmt_busy_o,
    input  wire logic                     cfg_lpbk_valid_i,
    input  wire logic                     cfg_lpbk_i,
    input  wire logic                     cap_full_i,
    input  wire logic                     cap_half_i,
    input  wire logic                     an_speed100_i,
    input  wire logic                     an_full_i,
    input  wire logic                     tx_en_i,
    input  wire logic [3:0]               txd_i,
    input  wire logic                     line_rx_dv_i,
    input  wire logic [3:0]               line_rxd_i,
    input  wire logic                     line_col_i,
    output logic                          rx_dv_o,
    output logic [3:0]                    rxd_o,
    output logic                          col_o,
    output logic                          rx_dead_o,
    output logic                          loopback_o,
    output logic                          speed100_o,
    output logic                          full_duplex_o,
    output logic                          an_enable_o,
    output logic                          an_restart_o,
    output logic                          power_down_o,
    output logic                          phy_reset_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // decode

    function automatic logic is_ctrl(input logic [`PMCR_ADDR_W-1:0] addr);
        is_ctrl = (addr == `PMCR_CTRL_OFFSET);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // management port and control register

    pmcr_pkg::pmcr_ctrl_t           ctrl_r;
    pmcr_pkg::pmcr_ctrl_t           ctrl_nxt;
    logic                           ack_r;
    logic                           ack_nxt;
    logic [`PMCR_DATA_W-1:0]        rdata_r;
    logic [`PMCR_DATA_W-1:0]        rdata_nxt;
    logic                           rst_start;
    logic                           rst_busy;
    logic                           take_rd;
    logic                           take_wr;
    logic [`PMCR_DATA_W-1:0]        wval;

    // reads stay answered during soft reset so software can poll bit 15
    assign take_rd = mgmt_req_i && !mgmt_wr_i;
    assign take_wr = mgmt_req_i && mgmt_wr_i && !rst_busy;
    // reserved bits are not stored, so they read zero whatever is written
    assign wval    = mgmt_wdata_i & `PMCR_WRITE_MASK;

    always_comb begin
        ctrl_nxt            = ctrl_r;
        ctrl_nxt.an_restart = 1'b0;
        ctrl_nxt.soft_reset = 1'b0;
        rst_start           = 1'b0;
        ack_nxt             = 1'b0;
        rdata_nxt           = rdata_r;
        if (take_wr && is_ctrl(mgmt_addr_i)) begin
            if (mgmt_wdata_i[`PMCR_BIT_RESET]) begin
                ctrl_nxt  = pmcr_pkg::pmcr_ctrl_t'(`PMCR_CTRL_RESET);
                rst_start = 1'b1;
            end else begin
                ctrl_nxt            = pmcr_pkg::pmcr_ctrl_t'(wval);
                ctrl_nxt.an_restart = mgmt_wdata_i[`PMCR_BIT_AN_RESTART];
            end
        end
        if (rst_busy) begin
            ctrl_nxt = pmcr_pkg::pmcr_ctrl_t'(`PMCR_CTRL_RESET);
        end
        // a single-mode phy can only report the mode it has
        if (cap_full_i && !cap_half_i) begin
            ctrl_nxt.full_duplex = 1'b1;
        end else if (cap_half_i && !cap_full_i) begin
            ctrl_nxt.full_duplex = 1'b0;
        end
        if (take_wr || take_rd) begin
            ack_nxt = 1'b1;
        end
        if (take_rd) begin
            if (is_ctrl(mgmt_addr_i)) begin
                rdata_nxt = ctrl_r;
                rdata_nxt[`PMCR_BIT_RESET] = rst_busy || rst_start;
            end else begin
                rdata_nxt = 16'h0000;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            ctrl_r  <= pmcr_pkg::pmcr_ctrl_t'(`PMCR_CTRL_RESET);
            ack_r   <= 1'b0;
            rdata_r <= 16'h0000;
        end else begin
            ctrl_r  <= ctrl_nxt;
            ack_r   <= ack_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    pmcr_rst_seq #(
        .RST_CYCLES (SOFT_RST_CYCLES)
    ) u_rst_seq (
        .clk_sys_i  (clk_sys_i),
        .reset_n_i  (reset_n_i),
        .start_i    (rst_start),
        .busy_o     (rst_busy)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // effective operating mode

    logic lpbk_eff;
    logic spd_nxt;
    logic dup_nxt;
    logic mode_lpbk_r;
    logic mode_spd_r;
    logic mode_dup_r;
    logic mode_an_r;
    logic mode_rst_r;
    logic mode_pd_r;

    // the strap outranks software once it is valid
    assign lpbk_eff = cfg_lpbk_valid_i ? cfg_lpbk_i : ctrl_r.loopback;

    always_comb begin
        if (ctrl_r.an_enable) begin
            spd_nxt = an_speed100_i;
            dup_nxt = an_full_i;
        end else begin
            spd_nxt = ctrl_r.speed100;
            dup_nxt = ctrl_r.full_duplex;
        end
        if (lpbk_eff) begin
            dup_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            mode_lpbk_r <= 1'b0;
            mode_spd_r  <= 1'b1;
            mode_dup_r  <= 1'b0;
            mode_an_r   <= 1'b1;
            mode_rst_r  <= 1'b0;
            mode_pd_r   <= 1'b0;
        end else begin
            mode_lpbk_r <= lpbk_eff;
            mode_spd_r  <= spd_nxt;
            mode_dup_r  <= dup_nxt;
            mode_an_r   <= ctrl_r.an_enable;
            mode_rst_r  <= rst_busy || rst_start;
            mode_pd_r   <= ctrl_r.power_down;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // data path

    pmcr_pkg::pmcr_nibble_t line_rx;
    pmcr_pkg::pmcr_nibble_t rx_path;

    assign line_rx.dv = line_rx_dv_i;
    assign line_rx.d  = line_rxd_i;

    pmcr_lpbk u_lpbk (
        .clk_sys_i    (clk_sys_i),
        .reset_n_i    (reset_n_i),
        .lpbk_i       (lpbk_eff),
        .coll_test_i  (ctrl_r.coll_test),
        .power_down_i (ctrl_r.power_down),
        .tx_en_i      (tx_en_i),
        .txd_i        (txd_i),
        .line_rx_i    (line_rx),
        .line_col_i   (line_col_i),
        .rx_o         (rx_path),
        .col_o        (col_o),
        .dead_o       (rx_dead_o)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    assign mgmt_ack_o    = ack_r;
    assign mgmt_rdata_o  = rdata_r;
    assign mgmt_busy_o   = rst_busy;
    assign rx_dv_o       = rx_path.dv;
    assign rxd_o         = rx_path.d;
    assign loopback_o    = mode_lpbk_r;
    assign speed100_o    = mode_spd_r;
    assign full_duplex_o = mode_dup_r;
    assign an_enable_o   = mode_an_r;
    assign an_restart_o  = ctrl_r.an_restart;
    assign power_down_o  = mode_pd_r;
    assign phy_reset_o   = mode_rst_r;

endmodule

// [testbench.sv]
// self-checking bench for the phy control register
// assumes pmcr_top, pmcr_mac_model and the bound monitor are compiled
`timescale 1ns/100ps

module testbench;
logic clk_sys_i = 1'b0, reset_n_i = 1'b0, cfg_lpbk_valid_i = 1'b0, cfg_lpbk_i = 1'b0;
logic cap_full_i = 1'b1, cap_half_i = 1'b1, an_speed100_i = 1'b1, an_full_i = 1'b0;
logic tx_en_i = 1'b0, line_rx_dv_i = 1'b0, line_col_i = 1'b0;
logic [3:0] txd_i = 4'h0, line_rxd_i = 4'h0;
logic mgmt_req_i, mgmt_wr_i, mgmt_ack_o, mgmt_busy_o, rx_dv_o, col_o, rx_dead_o, loopback_o;
logic speed100_o, full_duplex_o, an_enable_o, an_restart_o, power_down_o, phy_reset_o;
logic [4:0] mgmt_addr_i;
logic [15:0] mgmt_wdata_i, mgmt_rdata_o, q;
logic [3:0] rxd_o;
logic ack;
int err_count = 0, n_checks = 0, restarts = 0, dead_n = 0;

always #20 clk_sys_i = ~clk_sys_i;
// sampled mid-cycle so the pulse is seen once, away from the edge that launches it
always @(negedge clk_sys_i) if (an_restart_o === 1'b1) restarts++;

// short soft reset keeps the busy window easy to hit
pmcr_top #(.SOFT_RST_CYCLES(6)) i_pmcr_top (.clk_sys_i, .reset_n_i, .mgmt_req_i, .mgmt_wr_i, .mgmt_addr_i,
    .mgmt_wdata_i, .mgmt_ack_o, .mgmt_rdata_o, .mgmt_busy_o, .cfg_lpbk_valid_i, .cfg_lpbk_i, .cap_full_i,
    .cap_half_i, .an_speed100_i, .an_full_i, .tx_en_i, .txd_i, .line_rx_dv_i, .line_rxd_i, .line_col_i,
    .rx_dv_o, .rxd_o, .col_o, .rx_dead_o, .loopback_o, .speed100_o, .full_duplex_o, .an_enable_o,
    .an_restart_o, .power_down_o, .phy_reset_o);
pmcr_mac_model i_pmcr_mac_model (.clk_i(clk_sys_i), .ack_i(mgmt_ack_o), .rdata_i(mgmt_rdata_o),
    .req_o(mgmt_req_i), .wr_o(mgmt_wr_i), .addr_o(mgmt_addr_i), .wdata_o(mgmt_wdata_i));

////////////////////////////////////////////////////////////////////////////////
task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
        err_count++;
        $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
endtask
task automatic step(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
endtask
task automatic wr(input logic [4:0] a, input logic [15:0] d, input logic exp_ack);
    i_pmcr_mac_model.xfer(1'b1, a, d, ack, q);
    chk({15'h0000, ack}, {15'h0000, exp_ack});
endtask
task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    i_pmcr_mac_model.xfer(1'b0, a, 16'h0000, ack, q);
    chk(q, exp);
endtask
task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
endtask

initial begin
    #(40 * 3000);
    err_count++;
    close_out;
end

////////////////////////////////////////////////////////////////////////////////
initial begin
    step(20);
    reset_n_i = 1'b1;
    step(1);
    rd(5'h00, 16'h3000);
    wr(5'h01, 16'hffff, 1'b1);
    rd(5'h01, 16'h0000);
    rd(5'h00, 16'h3000);
    wr(5'h00, 16'h0100, 1'b1);
    step(2);
    chk({13'h0, speed100_o, full_duplex_o, an_enable_o}, 16'h0002);
    wr(5'h00, 16'h2000, 1'b1);
    step(2);
    chk({13'h0, speed100_o, full_duplex_o, an_enable_o}, 16'h0004);
    an_speed100_i = 1'b0;
    an_full_i = 1'b1;
    wr(5'h00, 16'h3000, 1'b1);
    step(2);
    chk({13'h0, speed100_o, full_duplex_o, an_enable_o}, 16'h0003);
    // every writable bit except loopback and soft reset; reserved bits left zero
    tx_en_i = 1'b1;
    line_rx_dv_i = 1'b1;
    wr(5'h00, 16'h3b80, 1'b1);
    rd(5'h00, 16'h3980);
    chk({13'h0, power_down_o, col_o, rx_dv_o}, 16'h0006);
    tx_en_i = 1'b0;
    step(2);
    chk({13'h0, power_down_o, col_o, rx_dv_o}, 16'h0004);
    restarts = 0;
    wr(5'h00, 16'h1200, 1'b1);
    rd(5'h00, 16'h1000);
    chk(16'(restarts), 16'h0001);
    cap_full_i = 1'b0;
    wr(5'h00, 16'h0100, 1'b1);
    rd(5'h00, 16'h0000);
    chk({15'h0, full_duplex_o}, 16'h0000);
    cap_full_i = 1'b1;
    // loopback with line activity present that must not reach the receive side
    line_rxd_i = 4'h5;
    line_col_i = 1'b1;
    tx_en_i = 1'b1;
    txd_i = 4'ha;
    wr(5'h00, 16'h4000, 1'b1);
    // the dead window opens on the edge the write returns after, so sample before stepping
    repeat (40) begin
        dead_n += int'(rx_dead_o);
        step(1);
    end
    chk(16'(dead_n), 16'h000e);
    chk({8'h0, col_o, rx_dv_o, rxd_o, full_duplex_o, loopback_o}, 16'h006b);
    txd_i = 4'h3;
    step(2);
    chk({12'h0, rxd_o}, 16'h0003);
    cfg_lpbk_valid_i = 1'b1;
    step(3);
    chk({9'h0, col_o, rx_dv_o, rxd_o, loopback_o}, 16'h006a);
    cfg_lpbk_valid_i = 1'b0;
    wr(5'h00, 16'h8000, 1'b1);
    chk({15'h0, phy_reset_o}, 16'h0001);
    rd(5'h00, 16'hb000);
    wr(5'h00, 16'h0000, 1'b0);
    for (int i = 0; i < 50 && mgmt_busy_o !== 1'b0; i++) step(1);
    chk({15'h0, mgmt_busy_o}, 16'h0000);
    rd(5'h00, 16'h3000);
    chk({14'h0, loopback_o, phy_reset_o}, 16'h0000);
    // configuration asks for loopback while the register bit is clear
    cfg_lpbk_i = 1'b1;
    cfg_lpbk_valid_i = 1'b1;
    step(2);
    chk({15'h0, loopback_o}, 16'h0001);
    close_out;
end
endmodule
